// >>> rtl/dwdg_consts.svh
`ifndef DWDG_CONSTS_SVH
`define DWDG_CONSTS_SVH

// I/O addresses
`define DW_ADR_UNITS 16'h0565
`define DW_ADR_COUNT 16'h0566
`define DW_ADR_CFG 16'h0567
`define DW_ADR_CTRL 16'h0568
`define DW_ADR_FEN 16'h118E
`define DW_ADR_KICK 16'h11B8

// Field positions
`define DW_FEN_DIS_BIT 6
`define DW_KICK_BIT 6
`define DW_LAMP_BIT 7
`define DW_UNITS_SEC_BIT 7
`define DW_CFG_KBD_BIT 1
`define DW_CFG_MOUSE_BIT 2
`define DW_CTRL_DONE_BIT 0
`define DW_CTRL_FORCE_BIT 2
`define DW_CTRL_KEY_BIT 3

// Reset values and control write mask
`define DW_FEN_RST 8'h40
`define DW_ZERO8 8'h00
`define DW_CTRL_KEEP 8'h08

// Timing
`define DW_CLK_HZ 10000000
`define DW_FIXED_TIMEOUT_MS 1600
`define DW_SECOND_MS 1000
`define DW_SEC_PER_MIN 6'h3B
`endif

// >>> rtl/dwdg_pkg.sv
package dwdg_pkg;
	// Programmable dog states
	typedef enum logic [1:0] {
		DWDG_IDLE = 2'b00,
		DWDG_RUN = 2'b01,
		DWDG_DONE = 2'b10
	} dwdg_state_t;
endpackage

// >>> rtl/dwdg_top.sv
`timescale 1ns/1ps
`include "dwdg_consts.svh"
module dwdg_top import dwdg_pkg::*; #(
	parameter int P_FIXED_CYC = `DW_FIXED_TIMEOUT_MS * (`DW_CLK_HZ / 1000),
	parameter int P_SEC_CYC = `DW_SECOND_MS * (`DW_CLK_HZ / 1000)
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	// Host I/O port
	input wire logic [15:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	// Input events
	input wire logic i_kbd_irq,
	input wire logic i_mouse_irq,
	input wire logic i_key_press,
	// Outputs
	output logic o_second_user_lamp,
	output logic o_wdog_trigger
);

	// Address match used by write and read decode
	function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
		hit = (a == r);
	endfunction

	logic [7:0] fen_q;
	logic [7:0] kick_q;
	logic [7:0] units_q;
	logic [7:0] count_q;
	logic [7:0] cfg_q;
	logic [7:0] ctrl_q;
	logic [23:0] fcnt_q;
	logic [23:0] sec_q;
	logic [5:0] min_q;
	logic [7:0] remain_q;
	dwdg_state_t state_q;
	logic wr_fen;
	logic wr_kick;
	logic wr_units;
	logic wr_count;
	logic wr_cfg;
	logic wr_ctrl;
	logic kick_toggle;
	logic fixed_exp;
	logic sec_tick;
	logic unit_tick;
	logic prog_restart;
	logic prog_force;
	logic prog_exp;

	// Write strobes, all gated by the clock enable
	assign wr_fen = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_FEN);
	assign wr_kick = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_KICK);
	assign wr_units = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_UNITS);
	assign wr_count = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_COUNT);
	assign wr_cfg = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_CFG);
	assign wr_ctrl = i_clk_en && i_io_wr && hit(i_io_addr, `DW_ADR_CTRL);

	// Fixed dog enable register; reserved bits stored as written
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			fen_q <= `DW_FEN_RST;
		end else if (wr_fen) begin
			fen_q <= i_io_wdata;
		end
	end

	// Kick and lamp register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			kick_q <= `DW_ZERO8;
		end else if (wr_kick) begin
			kick_q <= i_io_wdata;
		end
	end

	// Lamp driven straight from its stored bit
	assign o_second_user_lamp = kick_q[`DW_LAMP_BIT];

	// A toggle, not a level, services the dog; rewriting the same value does nothing
	assign kick_toggle = wr_kick && (i_io_wdata[`DW_KICK_BIT] != kick_q[`DW_KICK_BIT]);

	// Expiry on the last cycle of the fixed period
	assign fixed_exp = i_clk_en && !fen_q[`DW_FEN_DIS_BIT] && !kick_toggle
		&& (fcnt_q == 24'(P_FIXED_CYC - 1));

	// Fixed period counter; held at zero while disabled so enabling starts a full period
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			fcnt_q <= '0;
		end else if (i_clk_en) begin
			if (fen_q[`DW_FEN_DIS_BIT] || kick_toggle) begin
				fcnt_q <= '0;
			end else if (fixed_exp) begin
				fcnt_q <= '0;
			end else begin
				fcnt_q <= fcnt_q + 24'h000001;
			end
		end
	end

	// Units register; reserved bits kept for readback
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			units_q <= `DW_ZERO8;
		end else if (wr_units) begin
			units_q <= i_io_wdata;
		end
	end

	// Count register holds the reload value
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			count_q <= `DW_ZERO8;
		end else if (wr_count) begin
			count_q <= i_io_wdata;
		end
	end

	// Restart source configuration
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			cfg_q <= `DW_ZERO8;
		end else if (wr_cfg) begin
			cfg_q <= i_io_wdata;
		end
	end

	// Control: only the keypress enable is stored; force is a write-only action
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			ctrl_q <= `DW_ZERO8;
		end else if (wr_ctrl) begin
			ctrl_q <= i_io_wdata & `DW_CTRL_KEEP;
		end
	end

	// Restart and forced-end causes
	assign prog_restart = i_clk_en && (
		(cfg_q[`DW_CFG_KBD_BIT] && i_kbd_irq) ||
		(cfg_q[`DW_CFG_MOUSE_BIT] && i_mouse_irq));
	assign prog_force = (wr_ctrl && i_io_wdata[`DW_CTRL_FORCE_BIT]) ||
		(i_clk_en && ctrl_q[`DW_CTRL_KEY_BIT] && i_key_press);

	// Second prescaler runs only while counting, restarted on every reload
	assign sec_tick = i_clk_en && (sec_q == 24'(P_SEC_CYC - 1));
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			sec_q <= '0;
		end else if (i_clk_en) begin
			if (state_q != DWDG_RUN || wr_count || prog_restart || sec_tick) begin
				sec_q <= '0;
			end else begin
				sec_q <= sec_q + 24'h000001;
			end
		end
	end

	// Minute divider counts seconds; units may change mid-count without reload
	assign unit_tick = sec_tick && (units_q[`DW_UNITS_SEC_BIT] || min_q == `DW_SEC_PER_MIN);
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			min_q <= '0;
		end else if (i_clk_en) begin
			if (state_q != DWDG_RUN || wr_count || prog_restart || unit_tick) begin
				min_q <= '0;
			end else if (sec_tick) begin
				min_q <= min_q + 6'h01;
			end
		end
	end

	// Natural expiry on the last unit
	assign prog_exp = (state_q == DWDG_RUN) && unit_tick && (remain_q == 8'h01)
		&& !wr_count && !prog_force && !prog_restart;

	// Programmable dog state; a register write outranks events, a service beats expiry
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state_q <= DWDG_IDLE;
			remain_q <= `DW_ZERO8;
		end else if (i_clk_en) begin
			case (state_q)
				DWDG_IDLE: begin
					if (wr_count && i_io_wdata != `DW_ZERO8) begin
						state_q <= DWDG_RUN;
						remain_q <= i_io_wdata;
					end
				end
				DWDG_RUN: begin
					if (wr_count) begin
						if (i_io_wdata == `DW_ZERO8) begin
							state_q <= DWDG_IDLE;
						end
						remain_q <= i_io_wdata;
					end else if (prog_force) begin
						state_q <= DWDG_DONE;
						remain_q <= `DW_ZERO8;
					end else if (prog_restart) begin
						remain_q <= count_q;
					end else if (prog_exp) begin
						state_q <= DWDG_DONE;
						remain_q <= `DW_ZERO8;
					end else if (unit_tick) begin
						remain_q <= remain_q - 8'h01;
					end
				end
				DWDG_DONE: begin
					if (wr_count && i_io_wdata != `DW_ZERO8) begin
						state_q <= DWDG_RUN;
						remain_q <= i_io_wdata;
					end else if (wr_count) begin
						state_q <= DWDG_IDLE;
					end
				end
				default: begin
					state_q <= DWDG_IDLE;
				end
			endcase
		end
	end

	// Shared trigger pulse, one enabled cycle (held while i_clk_en is low), on expiry of either dog or a forced end; coincident causes give one pulse
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_wdog_trigger <= 1'b0;
		end else if (i_clk_en) begin
			o_wdog_trigger <= fixed_exp || prog_exp ||
				(state_q == DWDG_RUN && !wr_count && prog_force);
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_io_rdata <= `DW_ZERO8;
		end else if (i_clk_en && i_io_rd) begin
			if (hit(i_io_addr, `DW_ADR_FEN)) begin
				o_io_rdata <= fen_q;
			end else if (hit(i_io_addr, `DW_ADR_KICK)) begin
				o_io_rdata <= kick_q;
			end else if (hit(i_io_addr, `DW_ADR_UNITS)) begin
				o_io_rdata <= units_q;
			end else if (hit(i_io_addr, `DW_ADR_COUNT)) begin
				o_io_rdata <= count_q;
			end else if (hit(i_io_addr, `DW_ADR_CFG)) begin
				o_io_rdata <= cfg_q;
			end else if (hit(i_io_addr, `DW_ADR_CTRL)) begin
				o_io_rdata <= ctrl_q | {7'h00, state_q == DWDG_DONE};
			end else begin
				o_io_rdata <= `DW_ZERO8;
			end
		end
	end

	// Checks
	sequence s_force_write;
		i_clk_en && i_io_wr && i_io_addr == `DW_ADR_CTRL && i_io_wdata[`DW_CTRL_FORCE_BIT];
	endsequence

	sequence s_running;
		state_q == DWDG_RUN;
	endsequence

	sequence s_done_pulse;
		state_q == DWDG_DONE && o_wdog_trigger;
	endsequence

	a_fixed_reset_off: assert property (@(posedge i_sys_clk)
		!i_rst_b |=> fen_q[`DW_FEN_DIS_BIT] && fcnt_q == '0)
		else $error("fixed dog not disabled after reset");

	a_fixed_en_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wr_fen |=> fen_q[`DW_FEN_DIS_BIT] == $past(i_io_wdata[`DW_FEN_DIS_BIT]))
		else $error("fixed enable bit not stored");

	// A pulse right after a kick may still come from the programmable dog, never from the fixed one
	a_kick_restarts: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		kick_toggle |=> fcnt_q == '0 && (!o_wdog_trigger || $past(state_q == DWDG_RUN)))
		else $error("kick toggle did not restart fixed dog");

	a_fixed_timeout: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && !fen_q[`DW_FEN_DIS_BIT] && fcnt_q == 24'(P_FIXED_CYC - 1) && !kick_toggle
		|=> o_wdog_trigger && fcnt_q == '0)
		else $error("fixed dog expiry missed");

	a_lamp_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wr_kick |=> o_second_user_lamp == $past(i_io_wdata[`DW_LAMP_BIT]))
		else $error("lamp does not follow its bit");

	a_zero_disables: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wr_count && i_io_wdata == `DW_ZERO8 |=> state_q == DWDG_IDLE && (!o_wdog_trigger || $past(fixed_exp))
		##1 (!o_wdog_trigger || $past(fixed_exp || !i_clk_en)))
		else $error("zero count did not disable");

	a_load_runs: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		wr_count && i_io_wdata != `DW_ZERO8 |=> s_running and remain_q == $past(i_io_wdata))
		else $error("nonzero count did not start countdown");

	a_kbd_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (i_clk_en && cfg_q[`DW_CFG_KBD_BIT] && i_kbd_irq && !wr_count && !prog_force)
		|=> remain_q == $past(count_q) && state_q == DWDG_RUN)
		else $error("keyboard restart failed");

	a_force_trigger: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (s_force_write and !wr_count) |=> s_done_pulse)
		else $error("forced end did not trigger");

	a_key_ends: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (i_clk_en && ctrl_q[`DW_CTRL_KEY_BIT] && i_key_press && !i_io_wr) |=> s_done_pulse)
		else $error("keypress end did not trigger");

	a_status_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && i_io_rd && i_io_addr == `DW_ADR_CTRL
		|=> o_io_rdata[`DW_CTRL_DONE_BIT] == $past(state_q == DWDG_DONE))
		else $error("completion status wrong");

	a_seconds_tick: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (unit_tick && remain_q > 8'h01 && !wr_count && !prog_force && !prog_restart)
		|=> remain_q == $past(remain_q) - 8'h01)
		else $error("unit tick did not decrement");

	a_mouse_restart: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (i_clk_en && cfg_q[`DW_CFG_MOUSE_BIT] && i_mouse_irq && !wr_count && !prog_force)
		|=> remain_q == $past(count_q) && state_q == DWDG_RUN)
		else $error("mouse restart failed");

	// Last unit with nothing outranking it must end the count with a pulse
	a_count_expiry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		s_running and (unit_tick && remain_q == 8'h01 && !wr_count && !prog_force && !prog_restart)
		|=> s_done_pulse)
		else $error("count expiry missed");

	a_fixed_held_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && fen_q[`DW_FEN_DIS_BIT] |=> fcnt_q == '0)
		else $error("disabled fixed dog still counting");

	// With both dogs stopped nothing may raise the shared trigger
	a_no_cause_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
		i_clk_en && fen_q[`DW_FEN_DIS_BIT] && state_q != DWDG_RUN |=> !o_wdog_trigger)
		else $error("trigger without a running dog");

endmodule // dwdg_top

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	localparam int P_FIX = 50;
	localparam int P_SEC = 10;
	// Design stimulus and observed outputs
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_clk_en = 1'b1;
	logic [15:0] i_io_addr = 16'h0000;
	logic i_io_wr = 1'b0;
	logic i_io_rd = 1'b0;
	logic [7:0] i_io_wdata = 8'h00;
	logic [7:0] o_io_rdata;
	logic i_kbd_irq = 1'b0;
	logic i_mouse_irq = 1'b0;
	logic i_key_press = 1'b0;
	logic o_second_user_lamp;
	logic o_wdog_trigger;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;

	// Short counts keep the whole run under two thousand cycles
	dwdg_top #(.P_FIXED_CYC(P_FIX), .P_SEC_CYC(P_SEC)) dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.i_clk_en(i_clk_en), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
		.i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_kbd_irq(i_kbd_irq),
		.i_mouse_irq(i_mouse_irq), .i_key_press(i_key_press),
		.o_second_user_lamp(o_second_user_lamp), .o_wdog_trigger(o_wdog_trigger));

	// 10 MHz clock
	always #50 i_sys_clk = ~i_sys_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard, well above the expected run length
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// Strobes last one cycle, changed only on the falling edge
	// Idle cycle first, so back-to-back calls never lower and raise a strobe in one time step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_sys_clk);
		i_io_addr = a;
		i_io_wdata = d;
		i_io_wr = 1'b1;
		@(negedge i_sys_clk);
		i_io_wr = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge i_sys_clk);
		i_io_addr = a;
		i_io_rd = 1'b1;
		@(negedge i_sys_clk);
		i_io_rd = 1'b0;
		chk(o_io_rdata, exp, "read data");
	endtask

	task automatic no_trig(input int n);
		repeat (n) begin
			@(negedge i_sys_clk);
			chk({7'h00, o_wdog_trigger}, 8'h00, "early trigger");
		end
	endtask

	// Trigger must show between lo and hi cycles from now
	task automatic wait_trig(input int lo, input int hi);
		int n = 0;
		while (n < hi && o_wdog_trigger !== 1'b1) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk({7'h00, o_wdog_trigger}, 8'h01, "trigger missing");
		chk({7'h00, n >= lo}, 8'h01, "trigger too soon");
	endtask

	task automatic pulse(input int sel);
		if (sel == 0) i_kbd_irq = 1'b1;
		if (sel == 1) i_mouse_irq = 1'b1;
		if (sel == 2) i_key_press = 1'b1;
		@(negedge i_sys_clk);
		// Only the raised line drops, so a following pulse on another line is clean
		if (sel == 0) i_kbd_irq = 1'b0;
		if (sel == 1) i_mouse_irq = 1'b0;
		if (sel == 2) i_key_press = 1'b0;
	endtask

	task automatic t_reset();
		rd(16'h118E, 8'h40);
		rd(16'h11B8, 8'h00);
		rd(16'h0565, 8'h00);
		rd(16'h0566, 8'h00);
		rd(16'h0567, 8'h00);
		rd(16'h0568, 8'h00);
		wr(16'h0123, 8'hA5);
		rd(16'h0123, 8'h00);
		no_trig(120);
	endtask

	// Lamp follows bit 7; a write while frozen must be dropped
	task automatic t_lamp();
		i_clk_en = 1'b0;
		wr(16'h11B8, 8'h80);
		i_clk_en = 1'b1;
		@(negedge i_sys_clk);
		chk({7'h00, o_second_user_lamp}, 8'h00, "frozen write");
		wr(16'h11B8, 8'h80);
		chk({7'h00, o_second_user_lamp}, 8'h01, "lamp on");
		rd(16'h11B8, 8'h80);
		wr(16'h11B8, 8'h00);
		chk({7'h00, o_second_user_lamp}, 8'h00, "lamp off");
	endtask

	// Toggle kicks hold it off; a repeated value is no kick
	task automatic t_fixed();
		wr(16'h118E, 8'h00);
		no_trig(30);
		for (int k = 0; k < 4; k++) begin
			wr(16'h11B8, (k % 2 == 0) ? 8'h40 : 8'h00);
			no_trig(35);
		end
		wr(16'h11B8, 8'h00);
		wait_trig(P_FIX - 40, P_FIX - 32);
		// Step past the pulse just seen, or the next wait would stop on it at once
		@(negedge i_sys_clk);
		wait_trig(P_FIX - 2, P_FIX + 3);
		wr(16'h118E, 8'h40);
		no_trig(120);
	endtask

	task automatic t_prog();
		wr(16'h0565, 8'h80);
		rd(16'h0565, 8'h80);
		wr(16'h0566, 8'h03);
		rd(16'h0566, 8'h03);
		rd(16'h0568, 8'h00);
		wait_trig(3 * P_SEC - 5, 3 * P_SEC + 3);
		rd(16'h0568, 8'h01);
		wr(16'h0565, 8'h00);
		wr(16'h0566, 8'h01);
		wait_trig(60 * P_SEC - 2, 60 * P_SEC + 3);
		wr(16'h0566, 8'h05);
		no_trig(20);
		wr(16'h0566, 8'h00);
		no_trig(400);
		rd(16'h0568, 8'h00);
	endtask

	task automatic t_force_key();
		wr(16'h0565, 8'h80);
		wr(16'h0566, 8'hFF);
		no_trig(5);
		wr(16'h0568, 8'h04);
		wait_trig(0, 3);
		rd(16'h0568, 8'h01);
		wr(16'h0568, 8'h08);
		wr(16'h0566, 8'hFF);
		pulse(2);
		wait_trig(0, 3);
		rd(16'h0568, 8'h09);
		wr(16'h0568, 8'h00);
		wr(16'h0566, 8'h02);
		pulse(2);
		wait_trig(2 * P_SEC - 4, 2 * P_SEC + 3);
	endtask

	// Enabled sources restart, disabled ones do not
	task automatic t_irq();
		for (int s = 0; s < 2; s++) begin
			wr(16'h0567, (s == 0) ? 8'h02 : 8'h04);
			wr(16'h0566, 8'h02);
			repeat (3) begin
				no_trig(12);
				pulse(s);
			end
			wait_trig(2 * P_SEC - 3, 2 * P_SEC + 3);
		end
		wr(16'h0567, 8'h00);
		rd(16'h0567, 8'h00);
		wr(16'h0566, 8'h02);
		no_trig(12);
		pulse(0);
		pulse(1);
		wait_trig(3, 9);
	endtask

	initial begin
		repeat (12) @(negedge i_sys_clk);
		i_rst_b = 1'b1;
		@(negedge i_sys_clk);
		t_reset();
		t_lamp();
		t_fixed();
		t_prog();
		t_force_key();
		t_irq();
		stop_test();
	end
endmodule // tb_top
